// ===== rtl/smbus_config_slave_params.svh
// smbus_config_slave_params.svh: offsets, fields, reset values and timing counts of the serial config port
// Functional notes
// R1: accesses use a 7-bit address, then an 8-bit index, then an 8-bit data byte.
// R2: every byte on the data line moves most significant bit first.
// R3: write is start, address+0, ack, index, ack, data, ack, stop; one data byte only.
// R4: read writes the index, restarts with address+1, returns one byte, host nacks and stops.
// R5: registers change only after a complete valid write or read sequence.
// R6: only the pin-selected address is acked; anything else gets silence and idle.
// R7: the all-zero general call address is never acknowledged.
// R8: a clock-low interval over 25ms resets the port, ready for start within 35ms.
// R9: the port never holds the clock low and tolerates stretching by others.
// R10: a start followed at once by a stop returns the port to idle.
// R11: there is no alert output and no alert response address.
// R12: in serial mode the hub waits forever and attaches only on command.
// R13: pins shared with the eeprom port; serial mode disables eeprom loading.
// R14: seventeen 8-bit read/write registers at indices 00h through 10h.
// R15: writing 1 to status bit 2 restores defaults; the bit clears itself.
// R16: status bit 1 is a write-once lock on registers 01h-10h, cleared by reset only.
// R17: status bit 0 is write-once attach; the port powers down after its ack.
// R18: the host writes only zeros to status bits 7:3.
// R19: the host verifies the loaded data itself before locking it.
// R20: registers 01h-06h hold vendor, product and device id low/high bytes, reset 00h.
// R21: config byte one bit 7 selects self power unless dynamic switching uses the pin.
// R22: undefined indices read 00h; writes to them do nothing and raise no error.
// R23: after attach the port ignores all bus traffic until the reset pin.
`ifndef SMBUS_CONFIG_SLAVE_PARAMS_SVH
`define SMBUS_CONFIG_SLAVE_PARAMS_SVH

`define REG_STATUS_COMMAND 8'h00
`define REG_VENDOR_ID_LOW 8'h01
`define REG_VENDOR_ID_HIGH 8'h02
`define REG_PRODUCT_ID_LOW 8'h03
`define REG_PRODUCT_ID_HIGH 8'h04
`define REG_DEVICE_ID_LOW 8'h05
`define REG_DEVICE_ID_HIGH 8'h06
`define REG_CONFIG_BYTE_ONE 8'h07
`define REG_CONFIG_BYTE_TWO 8'h08
`define REG_FIXED_PORT_DEVICES 8'h09
`define REG_PORT_OFF_SELFPOWERED 8'h0A
`define REG_PORT_OFF_BUSPOWERED 8'h0B
`define REG_MAX_POWER_SELFPOWERED 8'h0C
`define REG_MAX_POWER_BUSPOWERED 8'h0D
`define REG_CTRL_CURRENT_SELFPOWERED 8'h0E
`define REG_CTRL_CURRENT_BUSPOWERED 8'h0F
`define REG_PORT_POWER_ON_DELAY 8'h10

`define STATUS_COMMAND_ATTACH_BIT 0
`define STATUS_COMMAND_LOCK_BIT 1
`define STATUS_COMMAND_SOFT_RESET_BIT 2
`define CONFIG_BYTE_ONE_SELF_POWER_BIT 7
`define CONFIG_BYTE_TWO_DYNAMIC_BIT 7

`define REG_RESET_VALUE 8'h00
`define UNDEF_READ_VALUE 8'h00
`define GENERAL_CALL_ADDR 7'h00
`define CFG_SEL_SERIAL_SLAVE 2'h1

`define REF_CLK_MHZ 25
`define T_TIMEOUT_MIN_US 25000
`define T_TIMEOUT_MAX_US 35000
`define TIMEOUT_CYCLES (`T_TIMEOUT_MIN_US * `REF_CLK_MHZ)

`endif

// ===== rtl/smbus_config_slave_pkg.sv
// smbus_config_slave_pkg.sv: types of the serial config port
package smbus_config_slave_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_INDEX = 4'h2,
    ST_INDEX_ACK = 4'h6,
    ST_WR_DATA = 4'h7,
    ST_WR_ACK = 4'h5,
    ST_WAIT_STOP = 4'h4,
    ST_RD_DATA = 4'hC,
    ST_RD_ACK = 4'hD
  } serial_state_t;

endpackage : smbus_config_slave_pkg

// ===== rtl/smbus_config_slave.sv
// smbus_config_slave.sv: serial slave that loads the hub configuration registers
`timescale 1ns/1ns
`include "smbus_config_slave_params.svh"

module smbus_config_slave
  import smbus_config_slave_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] slave_addr_pins,
  input wire logic config_source_select_hi,
  input wire logic config_source_select_lo,
  input wire logic self_power_sense_pin,
  output logic usb_attach,
  output logic config_lock,
  output logic eeprom_load_enable,
  output logic power_source_select,
  output logic [7:0] vendor_id_low_byte,
  output logic [7:0] vendor_id_high_byte,
  output logic [7:0] product_id_low_byte,
  output logic [7:0] product_id_high_byte,
  output logic [7:0] device_id_low_byte,
  output logic [7:0] device_id_high_byte,
  output logic [7:0] config_byte_one,
  output logic [7:0] config_byte_two,
  output logic [7:0] fixed_port_devices,
  output logic [7:0] port_off_selfpowered,
  output logic [7:0] port_off_buspowered,
  output logic [7:0] max_power_selfpowered,
  output logic [7:0] max_power_buspowered,
  output logic [7:0] controller_current_selfpowered,
  output logic [7:0] controller_current_buspowered,
  output logic [7:0] port_power_on_delay
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic sda_meta_ff, sda_sync_ff, sda_prev_ff;
  logic [6:0] addr_meta_ff, addr_sync_ff;
  logic [1:0] sel_meta_ff, sel_sync_ff;
  logic sense_meta_ff, sense_sync_ff;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [31:0] low_cnt_ff;
  logic timeout, serial_mode_ff, active, commit_wr;
  serial_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff, tx_ff, index_ff, wdata_ff, rd_val;
  logic got_index_ff, rd_ff, host_nack_ff, sda_oe_ff, sda_out_ff;
  logic soft_reset_ff, lock_ff, attach_ff, eeprom_en_ff, power_sel_ff;
  logic [7:0] cfg_ff [1:16];
  logic [127:0] cfg_flat;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic idx_defined(input logic [7:0] idx);
    idx_defined = (idx >= `REG_VENDOR_ID_LOW) && (idx <= `REG_PORT_POWER_ON_DELAY);
  endfunction : idx_defined
  function automatic logic [7:0] read_reg(input logic [7:0] idx);
    logic [7:0] val;
    val = `UNDEF_READ_VALUE;
    // soft reset bit always reads back as zero
    if (idx == `REG_STATUS_COMMAND) begin
      val[`STATUS_COMMAND_LOCK_BIT] = lock_ff;
      val[`STATUS_COMMAND_ATTACH_BIT] = attach_ff;
    end else if (idx_defined(idx)) begin
      val = cfg_ff[idx[4:0]];
    end
    read_reg = val;
  endfunction : read_reg
  always_comb rd_val = read_reg(index_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_in;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_in;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_meta_ff <= 7'h00;
      addr_sync_ff <= 7'h00;
      sel_meta_ff <= 2'h0;
      sel_sync_ff <= 2'h0;
      sense_meta_ff <= 1'b0;
      sense_sync_ff <= 1'b0;
    end else begin
      addr_meta_ff <= slave_addr_pins;
      addr_sync_ff <= addr_meta_ff;
      sel_meta_ff <= {config_source_select_hi, config_source_select_lo};
      sel_sync_ff <= sel_meta_ff;
      sense_meta_ff <= self_power_sense_pin;
      sense_sync_ff <= sense_meta_ff;
    end
  end

  assign scl_rise = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_sync_ff & scl_prev_ff;
  assign start_det = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  assign stop_det = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // mode select and clock-low timeout
  // R13 serial mode selection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_mode_ff <= 1'b0;
      eeprom_en_ff <= 1'b1;
    end else begin
      serial_mode_ff <= (sel_sync_ff == `CFG_SEL_SERIAL_SLAVE);
      eeprom_en_ff <= (sel_sync_ff != `CFG_SEL_SERIAL_SLAVE);
    end
  end
  // R23 powered down after attach
  assign active = serial_mode_ff & ~attach_ff;
  // R8 clock-low interval count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_cnt_ff <= 32'h0000_0000;
    end else if (scl_sync_ff || state_ff == ST_IDLE || timeout) begin
      low_cnt_ff <= 32'h0000_0000;
    end else begin
      low_cnt_ff <= low_cnt_ff + 32'h0000_0001;
    end
  end
  // resets at the least timeout, well inside the latest allowed
  assign timeout = (low_cnt_ff >= TIMEOUT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // serial state machine; no clock drive exists, so stretching is never done (R9)
  always_ff @(posedge ref_clk) begin
    if (rst || soft_reset_ff || timeout || !active) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
      got_index_ff <= 1'b0;
      rd_ff <= 1'b0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      index_ff <= 8'h00;
      wdata_ff <= 8'h00;
      host_nack_ff <= 1'b0;
    end else if (stop_det) begin
      // R10 start then stop idles
      state_ff <= ST_IDLE;
      sda_oe_ff <= 1'b0;
      got_index_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        ST_ADDR, ST_INDEX, ST_WR_DATA: begin
          // R1 R2 msb-first 8-bit shift in
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_sync_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          if (scl_fall && bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == ST_ADDR) begin
              // R6 R7 address match only
              if (shift_ff[7:1] != addr_sync_ff || shift_ff[7:1] == `GENERAL_CALL_ADDR) begin
                state_ff <= ST_IDLE;
                got_index_ff <= 1'b0;
              end else if (!shift_ff[0]) begin
                // R3 write address starts a fresh access
                state_ff <= ST_ADDR_ACK;
                sda_oe_ff <= 1'b1;
                rd_ff <= 1'b0;
                got_index_ff <= 1'b0;
              end else if (got_index_ff) begin
                // R4 read only after index
                state_ff <= ST_ADDR_ACK;
                sda_oe_ff <= 1'b1;
                rd_ff <= 1'b1;
              end else begin
                state_ff <= ST_IDLE;
              end
            end else if (state_ff == ST_INDEX) begin
              index_ff <= shift_ff;
              got_index_ff <= 1'b1;
              sda_oe_ff <= 1'b1;
              state_ff <= ST_INDEX_ACK;
            end else begin
              wdata_ff <= shift_ff;
              sda_oe_ff <= 1'b1;
              state_ff <= ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (rd_ff) begin
              tx_ff <= rd_val;
              sda_oe_ff <= ~rd_val[7];
              state_ff <= ST_RD_DATA;
            end else begin
              sda_oe_ff <= 1'b0;
              state_ff <= ST_INDEX;
            end
          end
        end
        ST_INDEX_ACK: begin
          // a repeated start from here is caught above
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            state_ff <= ST_WR_DATA;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            state_ff <= ST_WAIT_STOP;
          end
        end
        ST_WAIT_STOP: begin
          // R3 a second data byte is an invalid protocol
          if (scl_fall) begin
            state_ff <= ST_IDLE;
            got_index_ff <= 1'b0;
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          // R2 msb first shift out
          if (scl_fall) begin
            if (bit_cnt_ff == 4'h8) begin
              sda_oe_ff <= 1'b0;
              state_ff <= ST_RD_ACK;
            end else begin
              tx_ff <= {tx_ff[6:0], 1'b0};
              sda_oe_ff <= ~tx_ff[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            host_nack_ff <= sda_sync_ff;
          end
          // R4 only one byte; an ack from the host is invalid
          if (scl_fall) begin
            state_ff <= host_nack_ff ? ST_WAIT_STOP : ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // open drain: the data pin only ever pulls low
  always_ff @(posedge ref_clk) sda_out_ff <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  // R5 commit only on stop after a full write
  assign commit_wr = active & stop_det & ~timeout & ~soft_reset_ff & (state_ff == ST_WAIT_STOP) & ~rd_ff;
  // R15 self-clearing soft reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= commit_wr && index_ff == `REG_STATUS_COMMAND && wdata_ff[`STATUS_COMMAND_SOFT_RESET_BIT];
    end
  end
  // R16 R17 write-once bits, cleared by the reset pin only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_ff <= 1'b0;
      attach_ff <= 1'b0;
    end else if (commit_wr && index_ff == `REG_STATUS_COMMAND) begin
      lock_ff <= lock_ff | wdata_ff[`STATUS_COMMAND_LOCK_BIT];
      attach_ff <= attach_ff | wdata_ff[`STATUS_COMMAND_ATTACH_BIT];
    end
  end
  // R14 R20 R22 configuration bytes
  always_ff @(posedge ref_clk) begin
    if (rst || soft_reset_ff) begin
      for (int i = 1; i <= 16; i++) begin
        cfg_ff[i] <= `REG_RESET_VALUE;
      end
    end else if (commit_wr && !lock_ff && idx_defined(index_ff)) begin
      cfg_ff[index_ff[4:0]] <= wdata_ff;
    end
  end

  always_comb begin
    cfg_flat = 128'h0;
    for (int i = 1; i <= 16; i++) begin
      cfg_flat[(i - 1) * 8 +: 8] = cfg_ff[i];
    end
  end
  // R21 power source choice
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_sel_ff <= 1'b0;
    end else if (cfg_ff[8][`CONFIG_BYTE_TWO_DYNAMIC_BIT]) begin
      power_sel_ff <= sense_sync_ff;
    end else begin
      power_sel_ff <= cfg_ff[7][`CONFIG_BYTE_ONE_SELF_POWER_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs; R12 attach stays low until commanded, R11 no alert pin
  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;
  assign usb_attach = attach_ff;
  assign config_lock = lock_ff;
  assign eeprom_load_enable = eeprom_en_ff;
  assign power_source_select = power_sel_ff;
  assign vendor_id_low_byte = cfg_ff[1];
  assign vendor_id_high_byte = cfg_ff[2];
  assign product_id_low_byte = cfg_ff[3];
  assign product_id_high_byte = cfg_ff[4];
  assign device_id_low_byte = cfg_ff[5];
  assign device_id_high_byte = cfg_ff[6];
  assign config_byte_one = cfg_ff[7];
  assign config_byte_two = cfg_ff[8];
  assign fixed_port_devices = cfg_ff[9];
  assign port_off_selfpowered = cfg_ff[10];
  assign port_off_buspowered = cfg_ff[11];
  assign max_power_selfpowered = cfg_ff[12];
  assign max_power_buspowered = cfg_ff[13];
  assign controller_current_selfpowered = cfg_ff[14];
  assign controller_current_buspowered = cfg_ff[15];
  assign port_power_on_delay = cfg_ff[16];

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  a_general_call_quiet: assert property (@(posedge ref_clk) disable iff (rst) // R7
    (state_ff == ST_ADDR && scl_fall && bit_cnt_ff == 4'h8 && shift_ff[7:1] == `GENERAL_CALL_ADDR)
    |=> !sda_oe_ff [*2])
    else $error("general call was acknowledged");
  a_addr_mismatch_idle: assert property (@(posedge ref_clk) disable iff (rst) // R6
    (state_ff == ST_ADDR && scl_fall && bit_cnt_ff == 4'h8 && shift_ff[7:1] != addr_sync_ff && !start_det)
    |=> state_ff == ST_IDLE && !sda_oe_ff)
    else $error("foreign address not ignored");
  a_cfg_only_on_commit: assert property (@(posedge ref_clk) disable iff (rst) // R5
    !$stable(cfg_flat) |-> $past(commit_wr) || $past(soft_reset_ff))
    else $error("config changed without a valid write");
  a_lock_blocks_write: assert property (@(posedge ref_clk) disable iff (rst) // R16
    (commit_wr && lock_ff) |=> $stable(cfg_flat))
    else $error("locked register was written");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (rst) // R16
    lock_ff |=> lock_ff && $stable(lock_ff))
    else $error("lock bit cleared without reset");
  a_soft_reset_clears: assert property (@(posedge ref_clk) disable iff (rst) // R15
    soft_reset_ff |=> cfg_flat == 128'h0 && !soft_reset_ff && state_ff == ST_IDLE)
    else $error("soft reset did not restore defaults");
  a_attach_on_write: assert property (@(posedge ref_clk) disable iff (rst) // R17
    (commit_wr && index_ff == `REG_STATUS_COMMAND && wdata_ff[`STATUS_COMMAND_ATTACH_BIT]) |=> attach_ff)
    else $error("attach command not taken");
  a_attach_sleeps: assert property (@(posedge ref_clk) disable iff (rst) // R23
    attach_ff |-> state_ff == ST_IDLE && !sda_oe_ff)
    else $error("port active after attach");
  a_timeout_idle: assert property (@(posedge ref_clk) disable iff (rst) // R8
    timeout |=> state_ff == ST_IDLE && !sda_oe_ff && low_cnt_ff == 32'h0)
    else $error("clock-low timeout did not reset port");
  a_start_stop_idle: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (state_ff == ST_ADDR && bit_cnt_ff <= 4'h1 && stop_det) |=> state_ff == ST_IDLE)
    else $error("start then stop did not idle");

endmodule : smbus_config_slave

// ===== testbench/smbus_host_model.sv
// smbus_host_model.sv: behavioural serial host that loads the config port
`timescale 1ns/1ns

module smbus_host_model #(
  parameter int HALF = 10
) (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic scl_ff = 1'b1;
  logic sda_low_ff = 1'b0;
  int stretch = 0;
  assign scl = scl_ff;
  assign sda_low = sda_low_ff;

  task automatic gap();
    repeat (HALF) @(negedge ref_clk);
  endtask : gap

  // low phase may be stretched by the host
  task automatic pulse(output logic seen);
    gap();
    repeat (stretch) @(negedge ref_clk);
    scl_ff = 1'b1;
    gap();
    seen = sda;
    scl_ff = 1'b0;
  endtask : pulse

  // also serves as repeated start when the clock is low
  task automatic start();
    if (!scl_ff) begin
      sda_low_ff = 1'b0;
      gap();
      scl_ff = 1'b1;
    end
    gap();
    sda_low_ff = 1'b1;
    gap();
    scl_ff = 1'b0;
  endtask : start

  task automatic stop();
    sda_low_ff = 1'b1;
    gap();
    scl_ff = 1'b1;
    gap();
    sda_low_ff = 1'b0;
    gap();
  endtask : stop

  // msb first, data changed only while the clock is low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low_ff = ~b[i];
      pulse(s);
    end
    sda_low_ff = 1'b0;
    pulse(s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] b);
    logic s;
    sda_low_ff = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    pulse(s);
  endtask : recv_byte

  task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic [2:0] acks);
    start();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(idx, acks[1]);
    send_byte(d, acks[0]);
    stop();
  endtask : write_reg

  task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d, output logic [2:0] acks);
    start();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(idx, acks[1]);
    start();
    send_byte({a, 1'b1}, acks[0]);
    recv_byte(d);
    stop();
  endtask : read_reg
endmodule : smbus_host_model

// ===== testbench/smbus_config_slave_bench.sv
// smbus_config_slave_bench.sv: self-checking bench of the serial config port
`timescale 1ns/1ns

module smbus_config_slave_bench;
  localparam int TOUT = 200;
  localparam int LIMIT = 90000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] dev_addr = 7'h2C;
  logic sense = 1'b0;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b1;
  logic scl, host_low, sda_wire, sda_oe, sda_out;
  logic usb_attach, config_lock, eeprom_load_enable, power_source_select;
  logic [7:0] vendor_id_low_byte, vendor_id_high_byte, product_id_low_byte, product_id_high_byte;
  logic [7:0] device_id_low_byte, device_id_high_byte, config_byte_one, config_byte_two;
  logic [7:0] fixed_port_devices, port_off_selfpowered, port_off_buspowered, max_power_selfpowered;
  logic [7:0] max_power_buspowered, controller_current_selfpowered, controller_current_buspowered;
  logic [7:0] port_power_on_delay;
  logic [7:0] shadow [0:16];
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  integer seed = 32'h748c;

  // open-drain data line with pull-up
  assign sda_wire = ~(host_low | (sda_oe & ~sda_out));

  smbus_config_slave #(.TIMEOUT_CYCLES(TOUT)) i_smbus_config_slave (
    .ref_clk, .rst, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe, .slave_addr_pins(dev_addr),
    .config_source_select_hi(sel_hi), .config_source_select_lo(sel_lo), .self_power_sense_pin(sense),
    .usb_attach, .config_lock, .eeprom_load_enable, .power_source_select, .vendor_id_low_byte,
    .vendor_id_high_byte, .product_id_low_byte, .product_id_high_byte, .device_id_low_byte,
    .device_id_high_byte, .config_byte_one, .config_byte_two, .fixed_port_devices, .port_off_selfpowered,
    .port_off_buspowered, .max_power_selfpowered, .max_power_buspowered, .controller_current_selfpowered,
    .controller_current_buspowered, .port_power_on_delay
  );

  smbus_host_model i_smbus_host_model (.ref_clk, .sda(sda_wire), .scl, .sda_low(host_low));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] port_val(input int i);
    case (i)
      1: return vendor_id_low_byte;
      2: return vendor_id_high_byte;
      3: return product_id_low_byte;
      4: return product_id_high_byte;
      5: return device_id_low_byte;
      6: return device_id_high_byte;
      7: return config_byte_one;
      8: return config_byte_two;
      9: return fixed_port_devices;
      10: return port_off_selfpowered;
      11: return port_off_buspowered;
      12: return max_power_selfpowered;
      13: return max_power_buspowered;
      14: return controller_current_selfpowered;
      15: return controller_current_buspowered;
      default: return port_power_on_delay;
    endcase
  endfunction : port_val

  function automatic logic exp_power(input logic [7:0] c1, input logic [7:0] c2, input logic s);
    return c2[7] ? s : c1[7];
  endfunction : exp_power

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("counts: %0d compares, %0d fails", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, input logic [2:0] exp_acks);
    logic [2:0] acks;
    i_smbus_host_model.write_reg(a, idx, d, acks);
    check("write acks", {5'h00, acks}, {5'h00, exp_acks});
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [2:0] acks;
    logic [7:0] d;
    i_smbus_host_model.read_reg(dev_addr, idx, d, acks);
    check("read acks", {5'h00, acks}, 8'h07);
    check("read data", d, exp);
  endtask : rd

  task automatic cmp_all();
    for (int i = 1; i <= 16; i++) check($sformatf("reg %0d", i), port_val(i), shadow[i]);
  endtask : cmp_all

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      $display("ERROR watchdog expected done seen hang");
      finish_test();
    end
  end

  initial begin
    logic [7:0] v;
    logic ack;
    for (int i = 0; i <= 16; i++) shadow[i] = 8'h00;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    check("eeprom enable", {7'h00, eeprom_load_enable}, 8'h00);
    check("attach", {7'h00, usb_attach}, 8'h00);
    cmp_all();
    rd(8'h00, 8'h00);
    $display("test reset defaults done");
    for (int i = 1; i <= 16; i++) begin
      v = $random(seed);
      i_smbus_host_model.stretch = $random(seed) & 15;
      wr(dev_addr, i[7:0], v, 3'b111);
      shadow[i] = v;
    end
    cmp_all();
    for (int i = 1; i <= 16; i++) rd(i[7:0], shadow[i]);
    i_smbus_host_model.stretch = 0;
    $display("test random load done");
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h11 : (k == 1) ? 8'hFF : 8'h11 + ($random(seed) & 8'h7F);
      wr(dev_addr, v, 8'hA5, 3'b111);
      rd(v, 8'h00);
    end
    cmp_all();
    $display("test undefined index done");
    wr(dev_addr ^ 7'h01, 8'h01, ~shadow[1], 3'b000);
    wr(7'h00, 8'h02, ~shadow[2], 3'b000);
    cmp_all();
    $display("test foreign address done");
    i_smbus_host_model.start();
    i_smbus_host_model.send_byte({dev_addr, 1'b0}, ack);
    i_smbus_host_model.send_byte(8'h03, ack);
    i_smbus_host_model.stop();
    i_smbus_host_model.start();
    i_smbus_host_model.send_byte({dev_addr, 1'b0}, ack);
    i_smbus_host_model.start();
    i_smbus_host_model.stop();
    cmp_all();
    wr(dev_addr, 8'h03, 8'h5A, 3'b111);
    shadow[3] = 8'h5A;
    $display("test bus reset done");
    i_smbus_host_model.start();
    i_smbus_host_model.send_byte({dev_addr, 1'b0}, ack);
    i_smbus_host_model.send_byte(8'h04, ack);
    repeat (TOUT + 50) @(negedge ref_clk);
    i_smbus_host_model.send_byte(~shadow[4], ack);
    check("ack after timeout", {7'h00, ack}, 8'h00);
    i_smbus_host_model.stop();
    cmp_all();
    $display("test clock timeout done");
    for (int k = 0; k < 8; k++) begin
      shadow[7] = {k[0], 7'h15};
      shadow[8] = {k[1], 7'h10};
      wr(dev_addr, 8'h07, shadow[7], 3'b111);
      wr(dev_addr, 8'h08, shadow[8], 3'b111);
      @(negedge ref_clk);
      sense = k[2];
      repeat (8) @(negedge ref_clk);
      check("power select", {7'h00, power_source_select}, {7'h00, exp_power(shadow[7], shadow[8], sense)});
    end
    $display("test power select done");
    // status writes keep bits 7:3 zero
    wr(dev_addr, 8'h00, 8'h04, 3'b111);
    for (int i = 1; i <= 16; i++) shadow[i] = 8'h00;
    cmp_all();
    rd(8'h00, 8'h00);
    $display("test soft reset done");
    v = $random(seed);
    wr(dev_addr, 8'h03, v, 3'b111);
    rd(8'h03, v);
    shadow[3] = v;
    wr(dev_addr, 8'h00, 8'h02, 3'b111);
    check("lock", {7'h00, config_lock}, 8'h01);
    wr(dev_addr, 8'h03, ~v, 3'b111);
    rd(8'h03, v);
    wr(dev_addr, 8'h00, 8'h00, 3'b111);
    rd(8'h00, 8'h02);
    cmp_all();
    $display("test write protect done");
    wr(dev_addr, 8'h00, 8'h03, 3'b111);
    check("attach set", {7'h00, usb_attach}, 8'h01);
    wr(dev_addr, 8'h05, 8'h77, 3'b000);
    check("attach held", {7'h00, usb_attach}, 8'h01);
    cmp_all();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    check("lock cleared", {7'h00, config_lock}, 8'h00);
    check("attach cleared", {7'h00, usb_attach}, 8'h00);
    wr(dev_addr, 8'h05, 8'h77, 3'b111);
    check("reg after reset", device_id_low_byte, 8'h77);
    sel_lo = 1'b0;
    repeat (8) @(negedge ref_clk);
    check("eeprom mode", {7'h00, eeprom_load_enable}, 8'h01);
    wr(dev_addr, 8'h05, 8'h33, 3'b000);
    check("reg in eeprom mode", device_id_low_byte, 8'h77);
    $display("test attach and pin reset done");
    finish_test();
  end

endmodule : smbus_config_slave_bench
